// ==== core/tsrb_bank.sv ====
/*
  Register bank of the temperature sensor with its two-wire slave front
  end, conversion sequencer and over-temperature alarm.
  Assumes scl_in and sda_in come from pins in another clock domain, and
  that the analog converter answers conv_start with conv_done on clock.
*/
`timescale 1ns/1ps

//
// Contract
// - Four 16-bit registers at pointers 0 to 3: result, config, low, high.
// - Host writes never change read-only registers or read-only bits.
// - Short format: 15-bit result in bits 15..1, bit 0 reads zero.
// - Extended format, reset default: 16-bit result using every bit.
// - Bit 15 is the sign: zero positive, one negative.
// - Config bit 15 is read-only alarm flag, set when beyond limits.
// - Config bits 12:11 pick fault queue depth 1, 2, 4 or 6.
// - Config bit 9 picks comparison (0) or interrupt (1) alarm mode.
// - Config bit 8 picks continuous conversion (0) or shutdown (1).
// - Config bit 4 set disables the bus timeout reset; the bank has no timeout and only drives bus_timeout_disable.
// - Config bit 3 set enables bus error checking; the bank has no checking and only drives integrity_guard_on.
// - Config bit 0 shows one-shot busy; writing 1 in shutdown starts one.
// - Reserved config bits read-only; bit 6 reads one, others zero.
// - Limit registers share the result format of the current setting.
// - Format change never shifts or alters stored limits.
// - Comparison mode: set after N highs, clear after N lows.
// - Interrupt mode: any read clears; re-arms on opposite limit, alternating.
// - Continuous conversions repeat at 0.25, 1, 4 or 8 Hz.
// - Shutdown waits for running conversion; serial side stays alive.
module tsrb_bank
  import tsrb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
  parameter int unsigned RATE0_CYCLES = REFRESH0_MS * CLK_KHZ,
  parameter int unsigned RATE1_CYCLES = REFRESH1_MS * CLK_KHZ,
  parameter int unsigned RATE2_CYCLES = REFRESH2_MS * CLK_KHZ,
  parameter int unsigned RATE3_CYCLES = REFRESH3_MS * CLK_KHZ
) (
  input wire logic clock, // Core clock, 10 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic scl_in, // Serial clock pin level
  input wire logic sda_in, // Serial data pin level
  output logic sda_out, // Serial data drive level, always low
  output logic sda_oe, // High while pulling serial data low
  output logic conv_start, // One-cycle request to the converter
  input wire logic conv_done, // One-cycle converter completion
  input wire logic [15:0] conv_value, // Result, 2^-7 degree per step
  output logic bus_timeout_disable, // Timeout reset turned off
  output logic integrity_guard_on, // Error checking turned on
  output logic alarm_flag, // Over-temperature alarm
  output logic busy // Conversion running
);

  tsrb_state_t s;
  tsrb_state_t n;

  logic scl_v;
  logic sda_v;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic rd_evt;
  logic wr_evt;
  logic start_conv;
  logic [15:0] wdata;
  logic [15:0] cfg_word;
  logic [15:0] rd_word;
  logic [15:0] new_temp;
  logic [15:0] lo_eff;
  logic [15:0] hi_eff;
  logic [2:0] need;
  logic [2:0] hi_next;
  logic [2:0] lo_next;
  logic [TIMER_W-1:0] reload;

  // Line events seen through the second and third sampling stages
  assign scl_v = s.scl_sync[1];
  assign sda_v = s.sda_sync[1];
  assign scl_rise = scl_v & ~s.scl_sync[2];
  assign scl_fall = ~scl_v & s.scl_sync[2];
  assign start_det = scl_v & s.scl_sync[2] & s.sda_sync[2] & ~sda_v;
  assign stop_det = scl_v & s.scl_sync[2] & ~s.sda_sync[2] & sda_v;
  assign wdata = {s.wbuf, s.shreg};

  // Configuration word as read back, reserved bits fixed
  always_comb begin
    cfg_word = 16'h0000;
    cfg_word[CFG_ALARM] = s.alarm_flag;
    cfg_word[CFG_FQ_HI:CFG_FQ_LO] = s.fault_queue_depth;
    cfg_word[CFG_MODE] = s.alarm_mode_select;
    cfg_word[CFG_SD] = s.shutdown_ctrl;
    cfg_word[CFG_EM] = s.extended_format;
    cfg_word[CFG_ONE] = 1'b1;
    cfg_word[CFG_TO] = s.bus_timeout_disable;
    cfg_word[CFG_EC] = s.integrity_guard_on;
    cfg_word[CFG_CR_HI:CFG_CR_LO] = s.refresh_rate_select;
    cfg_word[CFG_OS] = s.one_shot_trigger;
  end

  // Register selected by the pointer
  always_comb begin
    case (s.ptr)
      PTR_TEMP: rd_word = s.temp;
      PTR_CFG: rd_word = cfg_word;
      PTR_LO: rd_word = s.lo_lim;
      PTR_HI: rd_word = s.hi_lim;
      default: rd_word = 16'h0000;
    endcase
  end

  // Result formatting and limit interpretation under the current format
  always_comb begin
    if (s.extended_format) begin
      new_temp = conv_value;
      lo_eff = s.lo_lim;
      hi_eff = s.hi_lim;
    end else begin
      new_temp = {conv_value[14:0], 1'b0};
      lo_eff = {s.lo_lim[15:1], 1'b0};
      hi_eff = {s.hi_lim[15:1], 1'b0};
    end
    case (s.fault_queue_depth)
      2'h0: need = FQ_DEPTH0;
      2'h1: need = FQ_DEPTH1;
      2'h2: need = FQ_DEPTH2;
      default: need = FQ_DEPTH3;
    endcase
    case (s.refresh_rate_select)
      2'h0: reload = TIMER_W'(RATE0_CYCLES - 1);
      2'h1: reload = TIMER_W'(RATE1_CYCLES - 1);
      2'h2: reload = TIMER_W'(RATE2_CYCLES - 1);
      default: reload = TIMER_W'(RATE3_CYCLES - 1);
    endcase
    // Consecutive event counters, saturating at the deepest queue
    if ($signed(new_temp) >= $signed(hi_eff)) begin
      hi_next = (s.hi_cnt < FQ_DEPTH3) ? s.hi_cnt + 3'h1 : s.hi_cnt;
      lo_next = 3'h0;
    end else if ($signed(new_temp) <= $signed(lo_eff)) begin
      hi_next = 3'h0;
      lo_next = (s.lo_cnt < FQ_DEPTH3) ? s.lo_cnt + 3'h1 : s.lo_cnt;
    end else begin
      hi_next = 3'h0;
      lo_next = 3'h0;
    end
  end

  // Next-state logic: serial slave, register writes, sequencer, alarm
  always_comb begin
    n = s;
    rd_evt = 1'b0;
    wr_evt = 1'b0;
    start_conv = 1'b0;
    n.conv_start = 1'b0;
    n.scl_sync = {s.scl_sync[1:0], scl_in};
    n.sda_sync = {s.sda_sync[1:0], sda_in};
    // Two-wire slave, alive in every power state
    if (start_det) begin
      n.st = S_ADDR;
      n.bitcnt = 4'h0;
      n.sda_oe = 1'b0;
    end else if (stop_det) begin
      n.st = S_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      case (s.st)
        S_ADDR, S_PTR, S_WDATA: begin
          if (scl_rise && s.bitcnt != BYTE_BITS) begin
            n.shreg = {s.shreg[6:0], sda_v};
            n.bitcnt = s.bitcnt + 4'h1;
          end else if (scl_fall && s.bitcnt == BYTE_BITS) begin
            n.bitcnt = 4'h0;
            n.st = S_ACK;
            n.sda_oe = 1'b1;
            case (s.st)
              S_ADDR: begin
                if (s.shreg[7:1] != DEV_ADDR) begin
                  n.st = S_IDLE;
                  n.sda_oe = 1'b0;
                end else if (s.shreg[0]) begin
                  n.txbuf = rd_word;
                  rd_evt = 1'b1;
                  n.after = S_RDATA;
                  n.byte_hi = 1'b1;
                end else begin
                  n.after = S_PTR;
                end
              end
              S_PTR: begin
                if (s.shreg[7:2] == 6'h00) begin
                  n.ptr = s.shreg[1:0];
                end
                n.after = S_WDATA;
                n.byte_hi = 1'b1;
              end
              default: begin
                n.after = S_WDATA;
                n.byte_hi = ~s.byte_hi;
                if (s.byte_hi) begin
                  n.wbuf = s.shreg;
                end else begin
                  wr_evt = 1'b1;
                end
              end
            endcase
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            n.st = s.after;
            if (s.after == S_RDATA) begin
              n.sda_oe = ~s.txbuf[15];
              n.txbuf = {s.txbuf[14:0], 1'b0};
              n.bitcnt = 4'h1;
            end else begin
              n.sda_oe = 1'b0;
            end
          end
        end
        S_RDATA: begin
          if (scl_fall) begin
            if (s.bitcnt == BYTE_BITS) begin
              n.sda_oe = 1'b0;
              n.st = S_RACK;
              n.bitcnt = 4'h0;
            end else begin
              n.sda_oe = ~s.txbuf[15];
              n.txbuf = {s.txbuf[14:0], 1'b0};
              n.bitcnt = s.bitcnt + 4'h1;
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            n.nack = sda_v;
          end else if (scl_fall) begin
            if (s.nack) begin
              n.st = S_IDLE;
            end else begin
              n.st = S_RDATA;
              n.byte_hi = ~s.byte_hi;
              n.bitcnt = 4'h1;
              if (s.byte_hi) begin
                n.sda_oe = ~s.txbuf[15];
                n.txbuf = {s.txbuf[14:0], 1'b0};
              end else begin
                n.sda_oe = ~rd_word[15];
                n.txbuf = {rd_word[14:0], 1'b0};
              end
            end
          end
        end
        default: n.st = S_IDLE;
      endcase
    end
    // Register writes; the result register ignores them
    if (wr_evt) begin
      case (s.ptr)
        PTR_CFG: begin
          n.fault_queue_depth = wdata[CFG_FQ_HI:CFG_FQ_LO];
          n.alarm_mode_select = wdata[CFG_MODE];
          n.shutdown_ctrl = wdata[CFG_SD];
          n.extended_format = wdata[CFG_EM];
          n.bus_timeout_disable = wdata[CFG_TO];
          n.integrity_guard_on = wdata[CFG_EC];
          n.refresh_rate_select = wdata[CFG_CR_HI:CFG_CR_LO];
          if (wdata[CFG_OS] && wdata[CFG_SD] && !s.converting) begin
            start_conv = 1'b1;
            n.one_shot_trigger = 1'b1;
          end
        end
        PTR_LO: n.lo_lim = wdata;
        PTR_HI: n.hi_lim = wdata;
        default: n.lo_lim = s.lo_lim;
      endcase
    end
    // Refresh timer; shutdown only blocks new starts
    if (s.timer != {TIMER_W{1'b0}}) begin
      n.timer = s.timer - TIMER_W'(1);
    end else if (!s.shutdown_ctrl && !s.converting) begin
      start_conv = 1'b1;
      n.timer = reload;
    end
    if (start_conv) begin
      n.converting = 1'b1;
      n.conv_start = 1'b1;
    end
    // Any register read clears the alarm in interrupt mode
    if (rd_evt && s.alarm_mode_select) begin
      n.alarm_flag = 1'b0;
    end
    // Completion: store result, run the fault queue; a set beats a read-clear
    if (s.converting && conv_done) begin
      n.converting = 1'b0;
      n.one_shot_trigger = 1'b0;
      n.temp = new_temp;
      n.hi_cnt = hi_next;
      n.lo_cnt = lo_next;
      if (!s.alarm_mode_select) begin
        if (hi_next >= need) begin
          n.alarm_flag = 1'b1;
        end else if (lo_next >= need) begin
          n.alarm_flag = 1'b0;
        end
      end else if (s.expect_high && hi_next >= need) begin
        n.alarm_flag = 1'b1;
        n.expect_high = 1'b0;
      end else if (!s.expect_high && lo_next >= need) begin
        n.alarm_flag = 1'b1;
        n.expect_high = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.scl_sync <= 3'h7;
      s.sda_sync <= 3'h7;
      s.st <= S_IDLE;
      s.after <= S_IDLE;
      s.temp <= TEMP_RESET;
      s.lo_lim <= LO_RESET;
      s.hi_lim <= HI_RESET;
      s.fault_queue_depth <= CFG_RESET[CFG_FQ_HI:CFG_FQ_LO];
      s.alarm_mode_select <= CFG_RESET[CFG_MODE];
      s.shutdown_ctrl <= CFG_RESET[CFG_SD];
      s.extended_format <= CFG_RESET[CFG_EM];
      s.bus_timeout_disable <= CFG_RESET[CFG_TO];
      s.integrity_guard_on <= CFG_RESET[CFG_EC];
      s.refresh_rate_select <= CFG_RESET[CFG_CR_HI:CFG_CR_LO];
      s.alarm_flag <= CFG_RESET[CFG_ALARM];
      s.expect_high <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign sda_out = s.sda_level;
  assign sda_oe = s.sda_oe;
  assign conv_start = s.conv_start;
  assign bus_timeout_disable = s.bus_timeout_disable;
  assign integrity_guard_on = s.integrity_guard_on;
  assign alarm_flag = s.alarm_flag;
  assign busy = s.converting;

endmodule : tsrb_bank

// ==== core/tsrb_pkg.sv ====
/*
  Package for the temperature sensor register bank: pointer codes, field
  positions, reset values, timing figures and the state record.
  Assumes a single 10 MHz core clock.
*/
package tsrb_pkg;

  // Core clock
  localparam int unsigned CLK_KHZ = 10000;

  // Refresh periods per rate code, in milliseconds
  localparam int unsigned REFRESH0_MS = 4000;
  localparam int unsigned REFRESH1_MS = 1000;
  localparam int unsigned REFRESH2_MS = 250;
  localparam int unsigned REFRESH3_MS = 125;
  localparam int TIMER_W = 26;

  // Register pointers
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG = 2'h1;
  localparam logic [1:0] PTR_LO = 2'h2;
  localparam logic [1:0] PTR_HI = 2'h3;

  // Configuration field positions
  localparam int CFG_ALARM = 15;
  localparam int CFG_FQ_HI = 12;
  localparam int CFG_FQ_LO = 11;
  localparam int CFG_MODE = 9;
  localparam int CFG_SD = 8;
  localparam int CFG_EM = 7;
  localparam int CFG_ONE = 6;
  localparam int CFG_TO = 4;
  localparam int CFG_EC = 3;
  localparam int CFG_CR_HI = 2;
  localparam int CFG_CR_LO = 1;
  localparam int CFG_OS = 0;

  // Reset values
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam logic [15:0] CFG_RESET = 16'h00C0;
  localparam logic [15:0] LO_RESET = 16'h4B00;
  localparam logic [15:0] HI_RESET = 16'h5000;

  // Fault queue depths per code
  localparam logic [2:0] FQ_DEPTH0 = 3'h1;
  localparam logic [2:0] FQ_DEPTH1 = 3'h2;
  localparam logic [2:0] FQ_DEPTH2 = 3'h4;
  localparam logic [2:0] FQ_DEPTH3 = 3'h6;

  // Serial framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h48;

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_PTR, S_WDATA, S_ACK, S_RDATA, S_RACK
  } tsrb_bus_e_t;

  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    tsrb_bus_e_t st;
    tsrb_bus_e_t after;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [15:0] txbuf;
    logic [7:0] wbuf;
    logic byte_hi;
    logic nack;
    logic [1:0] ptr;
    logic sda_oe;
    logic sda_level;
    logic [15:0] temp;
    logic [15:0] lo_lim;
    logic [15:0] hi_lim;
    logic alarm_flag;
    logic [1:0] fault_queue_depth;
    logic alarm_mode_select;
    logic shutdown_ctrl;
    logic extended_format;
    logic bus_timeout_disable;
    logic integrity_guard_on;
    logic [1:0] refresh_rate_select;
    logic one_shot_trigger;
    logic expect_high;
    logic [2:0] hi_cnt;
    logic [2:0] lo_cnt;
    logic converting;
    logic conv_start;
    logic [TIMER_W-1:0] timer;
  } tsrb_state_t;

endpackage : tsrb_pkg

// ==== tb/tsrb_bank_chk.sv ====
/*
  Port checker for tsrb_bank: converter handshake, alarm and config outputs.
  Assumes it is bound to every tsrb_bank instance.
*/
`timescale 1ns/1ps
module tsrb_chk
  import tsrb_pkg::*;
(
  input wire logic clock, // Core clock
  input wire logic rst_n, // Reset, active low
  input wire logic scl_in, // Serial clock level
  input wire logic sda_oe, // Device pulls data low
  input wire logic sda_out, // Drive level
  input wire logic conv_start, // Converter request
  input wire logic conv_done, // Converter completion
  input wire logic bus_timeout_disable, // Config bit 4
  input wire logic integrity_guard_on, // Config bit 3
  input wire logic alarm_flag, // Config bit 15
  input wire logic busy // Conversion running
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Steps of one conversion
  sequence s_req;
    conv_start && !$past(busy);
  endsequence
  sequence s_end;
    busy && conv_done;
  endsequence
  a_drive_zero: assert property (sda_out == 1'b0)
    else $error("drive level not low");
  a_start_pulse: assert property (conv_start |-> s_req ##1 !conv_start)
    else $error("start while busy or too long");
  a_busy_cause: assert property ($rose(busy) |-> conv_start)
    else $error("busy without start");
  a_busy_holds: assert property (busy && !conv_done |=> busy)
    else $error("busy dropped early");
  a_done_ends: assert property (s_end |=> !busy)
    else $error("busy after done");
  a_alarm_set: assert property ($rose(alarm_flag) |-> $past(conv_done) && $past(busy))
    else $error("alarm set without result");
  a_alarm_clear: assert property ($fell(alarm_flag) |-> $past(conv_done) || sda_oe)
    else $error("alarm cleared without cause");
  a_cfg_low: assert property ($changed(bus_timeout_disable) || $changed(integrity_guard_on)
    |-> !scl_in)
    else $error("config output changed outside write");
endmodule : tsrb_chk

bind tsrb_bank tsrb_chk u_chk (.clock(clock), .rst_n(rst_n), .scl_in(scl_in), .sda_oe(sda_oe),
  .sda_out(sda_out), .conv_start(conv_start), .conv_done(conv_done),
  .bus_timeout_disable(bus_timeout_disable), .integrity_guard_on(integrity_guard_on),
  .alarm_flag(alarm_flag), .busy(busy));

// ==== tb/tsrb_host.sv ====
/*
  Two-wire host model: open-drain lines with pull-ups, byte transfers.
  Assumes a link clock period of 800 ns, low and high for 400 ns each.
*/
`timescale 1ns/1ps
module tsrb_host (
  input wire logic dev_oe, // Device pulls data low
  output logic scl, // Serial clock line
  output logic sda // Serial data line
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // Wired-and lines, released lines float high
  assign scl = !scl_low;
  assign sda = !(sda_low || dev_oe);
  // Start: data falls while clock high
  task automatic start();
    #100 sda_low = 1'b0;
    #400 scl_low = 1'b0;
    #500 sda_low = 1'b1;
    #500 scl_low = 1'b1;
  endtask : start
  // Stop: data rises while clock high
  task automatic stop();
    #100 sda_low = 1'b1;
    #400 scl_low = 1'b0;
    #500 sda_low = 1'b0;
    #500;
  endtask : stop
  // One 800 ns bit: drive after fall, sample mid-high
  task automatic bit_io(input logic b, output logic r);
    #100 sda_low = !b;
    #300 scl_low = 1'b0;
    #200 r = sda;
    #200 scl_low = 1'b1;
  endtask : bit_io
  // Byte MSB first, then the ninth acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
    output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(last, ack);
  endtask : xfer
endmodule : tsrb_host

// ==== tb/testbench.sv ====
/*
  Testbench for tsrb_bank: host accesses, converter model, register model.
  Assumes shortened refresh periods set through the parameters.
*/
`timescale 1ns/1ps
module testbench;
  import tsrb_pkg::*;
  localparam int unsigned R0 = 200, R1 = 150, R2 = 100, R3 = 80;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic conv_done = 1'b0;
  logic [15:0] conv_value = 16'h0000;
  logic scl, sda, sda_out, sda_oe, conv_start, busy, alarm_flag;
  logic bus_timeout_disable, integrity_guard_on, ack;
  logic [15:0] q;
  int miscompares = 0;
  int n_compared = 0;
  int mr[4] = '{'h0000, 'h00C0, 'h4B00, 'h5000};
  int mp = 0;
  int lat = 0;
  int dep[4] = '{1, 2, 4, 6};
  int per[4] = '{R0, R1, R2, R3};

  always #50 clock = !clock;

  tsrb_bank #(.RATE0_CYCLES(R0), .RATE1_CYCLES(R1), .RATE2_CYCLES(R2), .RATE3_CYCLES(R3))
  u_tsrb_bank (.clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .conv_start(conv_start), .conv_done(conv_done), .conv_value(conv_value),
    .bus_timeout_disable(bus_timeout_disable), .integrity_guard_on(integrity_guard_on),
    .alarm_flag(alarm_flag), .busy(busy));

  tsrb_host u_tsrb_host (.dev_oe(sda_oe), .scl(scl), .sda(sda));

  // Converter model, varying answer delay; keeps the result model
  always @(negedge clock) begin
    conv_done <= 1'b0;
    if (conv_start) begin
      lat <= 2 + n_compared % 9;
    end else if (lat > 1) begin
      lat <= lat - 1;
    end else if (lat == 1) begin
      lat <= 0;
      conv_done <= 1'b1;
      mr[0] <= mr[1][7] ? conv_value : {conv_value[14:0], 1'b0};
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Pointer write with optional data word; updates the register model
  task automatic wr(input logic [7:0] p, input logic [15:0] w, input logic dat);
    logic [7:0] b[4];
    logic [7:0] x;
    logic nak;
    b = '{{DEV_ADDR_DEFAULT, 1'b0}, p, w[15:8], w[7:0]};
    nak = 1'b0;
    // Model first: a started conversion can end before STOP
    if (p < 4) mp = p;
    if (dat && p == 1) mr[1] = (w & 16'h1B9E) | 16'h0040;
    else if (dat && p > 1 && p < 4) mr[p] = w;
    u_tsrb_host.start();
    for (int i = 0; i < (dat ? 4 : 2); i++) begin
      u_tsrb_host.xfer(b[i], 1'b1, x, ack);
      nak |= ack;
    end
    u_tsrb_host.stop();
    check({15'h0, nak}, 16'h0000, "write ack");
  endtask : wr

  // Word read from the selected register
  task automatic rd();
    logic a;
    u_tsrb_host.start();
    u_tsrb_host.xfer({DEV_ADDR_DEFAULT, 1'b1}, 1'b1, q[7:0], a);
    u_tsrb_host.xfer(8'hFF, 1'b0, q[15:8], ack);
    u_tsrb_host.xfer(8'hFF, 1'b1, q[7:0], ack);
    u_tsrb_host.stop();
    check({15'h0, a}, 16'h0000, "read ack");
    if (mp == 1) q[15] = 1'b0;
    check(q, mr[mp][15:0], "read");
  endtask : rd

  // Single conversion in shutdown with a given result
  task automatic shot(input logic [15:0] v, input logic [15:0] c);
    int i;
    @(negedge clock) conv_value = v;
    wr(8'h1, c | 16'h0101, 1'b1);
    i = 0;
    while (busy !== 1'b0 && i < 50) begin
      @(negedge clock);
      i++;
    end
    check({15'h0, busy}, 16'h0000, "shot done");
  endtask : shot

  task automatic alarm(input logic e);
    check({15'h0, alarm_flag}, {15'h0, e}, "alarm");
  endtask : alarm

  // Watchdog
  initial begin
    repeat (80000) @(posedge clock);
    miscompares++;
    final_report();
  end

  // Main sequence
  initial begin
    logic [15:0] v;
    int n;
    void'($urandom(33869));
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    for (int p = 0; p < 4; p++) begin
      wr(8'(p), 16'h0000, 1'b0);
      rd();
    end
    wr(8'h0, 16'hFFFF, 1'b1);
    rd();
    wr(8'h1, 16'hFFFE, 1'b1);
    rd();
    check({15'h0, bus_timeout_disable}, 16'h0001, "timeout");
    check({15'h0, integrity_guard_on}, 16'h0001, "check");
    wr(8'h7, 16'h0000, 1'b0);
    rd();
    u_tsrb_host.start();
    u_tsrb_host.xfer({7'h49, 1'b0}, 1'b1, q[7:0], ack);
    u_tsrb_host.stop();
    check({15'h0, ack}, 16'h0001, "foreign address");
    v = 16'($urandom);
    wr(8'h2, v, 1'b1);
    rd();
    wr(8'h1, 16'h0100, 1'b1);
    wr(8'h2, 16'h0000, 1'b0);
    rd();
    v = 16'($urandom) | 16'h8000;
    shot(v, 16'h0100);
    wr(8'h0, 16'h0000, 1'b0);
    rd();
    shot(v, 16'h0180);
    wr(8'h0, 16'h0000, 1'b0);
    rd();
    check({15'h0, q[15]}, 16'h0001, "sign");
    wr(8'h2, 16'h1000, 1'b1);
    wr(8'h3, 16'h2000, 1'b1);
    shot(16'h3000, 16'h0380);
    alarm(1'b1);
    rd();
    alarm(1'b0);
    shot(16'h3000, 16'h0380);
    alarm(1'b0);
    shot(16'h0800, 16'h0380);
    alarm(1'b1);
    rd();
    alarm(1'b0);
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < dep[c]; k++) begin
        shot(16'h3000, 16'(c << 11) | 16'h0180);
        alarm(k == dep[c] - 1);
      end
      for (int k = 0; k < dep[c]; k++) begin
        shot(16'h0800, 16'(c << 11) | 16'h0180);
        alarm(k != dep[c] - 1);
      end
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h1, 16'(c << 1) | 16'h0080, 1'b1);
      n = 0;
      while (conv_start !== 1'b1 && n < 300) begin
        @(negedge clock);
        n++;
      end
      @(negedge clock);
      n = 1;
      while (conv_start !== 1'b1 && n < 300) begin
        @(negedge clock);
        n++;
      end
      check(16'(n), 16'(per[c]), "period");
    end
    final_report();
  end
endmodule : testbench
